// ==== core/rtpoam_defines.vh ====
`ifndef RTPOAM_DEFINES_VH
`define RTPOAM_DEFINES_VH
// rtp header constants
`define RTPOAM_RTP_VER 2'h2
`define RTPOAM_RTP_PXCCM 6'h00
`define RTPOAM_RTP_MARKER 1'b0
// payload kinds carried after the headers
`define RTPOAM_KIND_AAL1 2'h0
`define RTPOAM_KIND_HDLC 2'h1
`define RTPOAM_KIND_RAW 2'h2
`define RTPOAM_KIND_OAM 2'h3
// oam classification and fields
`define RTPOAM_VCCV_NIBBLE 4'h1
`define RTPOAM_UDP_NIBBLE 4'h0
`define RTPOAM_FMT_ID 4'h0
`define RTPOAM_VCCV_RES 8'h00
`define RTPOAM_UDP_RES 2'h0
`define RTPOAM_TYPE_QUERY 8'h00
`define RTPOAM_TYPE_REPLY 8'h08
`define RTPOAM_CODE_ACK 8'h00
`define RTPOAM_CODE_BAD 8'h01
`define RTPOAM_SVC_NONE 16'h0000
`define RTPOAM_TS_NONE 32'h0000_0000
// udp oam message length in bytes, with and without delay stamps
`define RTPOAM_LEN_SHORT 6'h0c
`define RTPOAM_LEN_LONG 6'h18
// frame buffer
`define RTPOAM_MEM_DEPTH 6
`define RTPOAM_RTP_WORDS 3'h3
`define RTPOAM_VCCV_WORDS 3'h2
`define RTPOAM_UDP_WORDS 3'h3
`define RTPOAM_TS_WORDS 3'h3
// oam bundle id table
`define RTPOAM_TBL_DEPTH 8
// timing
`define RTPOAM_ABS_TICK_US 125
// stamp steps in 50 MHz cycles, sized to match the divider
`define RTPOAM_FINE_CYC 16'h0032
`define RTPOAM_COARSE_CYC 16'h1388
// lfsr seed and taps for the source identifier
`define RTPOAM_LFSR_SEED 32'hace1_2468
`define RTPOAM_LFSR_TAPS 32'h8020_0003
`endif

// ==== core/rtpoam_framer.v ====
// Function
// - rtp header version field is always 2
// - padding, extension, marker and csrc count are zero
// - payload type per direction from dynamic range, may be shared
// - rtp sequence number copies control word sequence number
// - absolute mode timestamp comes from the tdm circuit clock
// - absolute mode timestamp steps by one each 125 us
// - differential mode uses the shared network clock for timestamps
// - source identifier is chosen randomly per session
// - payload is aal1, hdlc, raw or oam
// - inband oam uses the data bundle identifier
// - first nibble 0001 after psn layers marks inband oam
// - inband oam is diverted before control word processing
// - inband oam psn layers equal the data psn layers
// - format identifier and reserved field of inband oam are zero
// - channel type holds the assigned verification oam value
// - udp oam uses a bundle id preset in the oam table
// - udp oam psn layers equal data layers except bundle id
// - message type 0 is query, 8 is reply
// - reply code 0 acknowledges, 1 flags configuration mismatch
// - timestamps only when measuring delay, 100 us or 1 us
// - l, r and m bits match the bundle under test
`default_nettype none
`include "rtpoam_defines.vh"
module rtpoam_framer #(
  parameter [15:0] CHAN_TYPE = 16'h0001, // arbitrary channel type value
  parameter [15:0] COARSE_CYC = `RTPOAM_COARSE_CYC
) (
  input wire sys_clk_i,
  input wire srst_i,
  input wire ce_i,
  input wire tdm_frame_i,
  input wire net_tick_i,
  input wire ts_diff_mode_i,
  input wire ts_coarse_i,
  input wire delay_meas_i,
  input wire new_session_i,
  input wire tx_data_req_i,
  input wire [1:0] tx_kind_i,
  input wire [15:0] tx_seq_i,
  input wire [6:0] tx_pt_i,
  input wire [15:0] tx_bid_i,
  input wire tx_vccv_req_i,
  input wire tx_udp_req_i,
  input wire oam_reply_i,
  input wire oam_query_code_i,
  input wire oam_mismatch_i,
  input wire [15:0] oam_rx_seq_i,
  input wire [31:0] oam_rx_time_i,
  input wire [31:0] oam_src_time_i,
  input wire [15:0] oam_bid_i,
  input wire [15:0] oam_dst_bid_i,
  input wire l_bit_i,
  input wire r_bit_i,
  input wire [1:0] m_bits_i,
  input wire tbl_wr_i,
  input wire [2:0] tbl_idx_i,
  input wire tbl_en_i,
  input wire [15:0] tbl_bid_i,
  input wire rx_valid_i,
  input wire [3:0] rx_nibble_i,
  input wire [15:0] rx_bid_i,
  output reg ready_o,
  output reg tx_refused_o,
  output reg word_valid_o,
  output reg word_last_o,
  output reg [31:0] word_o,
  output reg [1:0] word_kind_o,
  output reg [15:0] psn_bid_o,
  output reg rx_vccv_o,
  output reg rx_udp_oam_o,
  output reg rx_data_o
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_SEND = 2'h1;

  reg [1:0] state_reg;
  reg [31:0] frm_mem [0:`RTPOAM_MEM_DEPTH-1];
  reg [2:0] rd_idx_reg;
  reg [2:0] last_idx_reg;
  reg [31:0] lfsr_reg;
  reg [31:0] sync_source_identifier_reg;
  reg [15:0] oam_seq_reg;
  reg [15:0] res_div_reg;
  reg [31:0] us_time_reg;
  reg [`RTPOAM_TBL_DEPTH-1:0] tbl_en_reg;
  reg [15:0] tbl_bid_reg [0:`RTPOAM_TBL_DEPTH-1];
  wire [31:0] abs_ts;
  wire [31:0] net_ts;
  wire [31:0] rtp_ts;
  wire [15:0] res_lim;
  wire [15:0] tx_oam_seq;
  wire [7:0] tx_oam_type;
  wire [7:0] tx_oam_code;
  wire [5:0] udp_len;
  wire tx_bid_ok;
  wire rx_bid_hit;
  wire take_req;
  integer i;

  // bundle id lookup in the oam table
  function tbl_hit;
    input [15:0] bid;
    input [`RTPOAM_TBL_DEPTH-1:0] en;
    input [16*`RTPOAM_TBL_DEPTH-1:0] flat;
    integer k;
    begin
      tbl_hit = 1'b0;
      for (k = 0; k < `RTPOAM_TBL_DEPTH; k = k + 1) begin
        if (en[k] && (flat[16*k +: 16] == bid)) begin
          tbl_hit = 1'b1;
        end
      end
    end
  endfunction

  // flattened view of the table for the lookup function
  reg [16*`RTPOAM_TBL_DEPTH-1:0] tbl_flat;
  always @* begin
    tbl_flat = {16*`RTPOAM_TBL_DEPTH{1'b0}};
    for (i = 0; i < `RTPOAM_TBL_DEPTH; i = i + 1) begin
      tbl_flat[16*i +: 16] = tbl_bid_reg[i];
    end
  end

  assign tx_bid_ok = tbl_hit(oam_bid_i, tbl_en_reg, tbl_flat);
  assign rx_bid_hit = tbl_hit(rx_bid_i, tbl_en_reg, tbl_flat);

  // tdm frame pulses and network clock ticks, both from pins
  rtpoam_tick_cnt u_abs_cnt (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .pin_i(tdm_frame_i),
    .cnt_o(abs_ts)
  );

  rtpoam_tick_cnt u_net_cnt (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .pin_i(net_tick_i),
    .cnt_o(net_ts)
  );

  // one tdm frame is one timestamp unit in absolute mode
  assign rtp_ts = ts_diff_mode_i ? net_ts : abs_ts;

  // oam field selection
  assign tx_oam_type = oam_reply_i ? `RTPOAM_TYPE_REPLY : `RTPOAM_TYPE_QUERY;
  assign tx_oam_code = oam_reply_i ?
    (oam_mismatch_i ? `RTPOAM_CODE_BAD : `RTPOAM_CODE_ACK) :
    {7'h00, oam_query_code_i};
  // queries take a fresh number, replies echo the query
  assign tx_oam_seq = oam_reply_i ? oam_rx_seq_i : oam_seq_reg;
  assign udp_len = delay_meas_i ? `RTPOAM_LEN_LONG : `RTPOAM_LEN_SHORT;
  assign res_lim = ts_coarse_i ? COARSE_CYC : `RTPOAM_FINE_CYC;
  assign take_req = ce_i && (state_reg == ST_IDLE);

  // delay stamp clock at the selected resolution
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      res_div_reg <= 16'h0000;
      us_time_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      if (res_div_reg >= res_lim - 16'h0001) begin
        res_div_reg <= 16'h0000;
        us_time_reg <= us_time_reg + 32'h0000_0001;
      end else begin
        res_div_reg <= res_div_reg + 16'h0001;
      end
    end
  end

  // free-running lfsr; the source id is sampled from it per session
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      lfsr_reg <= `RTPOAM_LFSR_SEED;
      sync_source_identifier_reg <= `RTPOAM_LFSR_SEED;
    end else if (ce_i) begin
      lfsr_reg <= lfsr_reg[0] ? ((lfsr_reg >> 1) ^ `RTPOAM_LFSR_TAPS) : (lfsr_reg >> 1);
      if (new_session_i) begin
        sync_source_identifier_reg <= lfsr_reg;
      end
    end
  end

  // oam bundle id table, written by the host side config logic
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      tbl_en_reg <= {`RTPOAM_TBL_DEPTH{1'b0}};
    end else if (ce_i && tbl_wr_i) begin
      tbl_en_reg[tbl_idx_i] <= tbl_en_i;
    end
  end

  always @(posedge sys_clk_i) begin
    if (ce_i && tbl_wr_i) begin
      tbl_bid_reg[tbl_idx_i] <= tbl_bid_i;
    end
  end

  // receive classifier; one pulse per packet head
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      rx_vccv_o <= 1'b0;
      rx_udp_oam_o <= 1'b0;
      rx_data_o <= 1'b0;
    end else if (ce_i) begin
      rx_vccv_o <= 1'b0;
      rx_udp_oam_o <= 1'b0;
      rx_data_o <= 1'b0;
      if (rx_valid_i) begin
        if (rx_bid_hit) begin
          rx_udp_oam_o <= 1'b1;
        end else if (rx_nibble_i == `RTPOAM_VCCV_NIBBLE) begin
          // diverted here so the control word path never sees it
          rx_vccv_o <= 1'b1;
        end else begin
          rx_data_o <= 1'b1;
        end
      end
    end
  end

  // frame builder: a whole frame is written in one cycle, then streamed
  always @(posedge sys_clk_i) begin
    if (take_req && tx_data_req_i) begin
      frm_mem[0] <= {`RTPOAM_RTP_VER, `RTPOAM_RTP_PXCCM, `RTPOAM_RTP_MARKER,
                     tx_pt_i, tx_seq_i};
      frm_mem[1] <= rtp_ts;
      frm_mem[2] <= sync_source_identifier_reg;
    end else if (take_req && tx_vccv_req_i) begin
      frm_mem[0] <= {`RTPOAM_VCCV_NIBBLE, `RTPOAM_FMT_ID, `RTPOAM_VCCV_RES,
                     CHAN_TYPE};
      frm_mem[1] <= {tx_oam_type, tx_oam_code, `RTPOAM_SVC_NONE};
      frm_mem[2] <= oam_reply_i ? oam_src_time_i : us_time_reg;
      frm_mem[3] <= oam_reply_i ? oam_rx_time_i : `RTPOAM_TS_NONE;
      frm_mem[4] <= oam_reply_i ? us_time_reg : `RTPOAM_TS_NONE;
    end else if (take_req && tx_udp_req_i && tx_bid_ok) begin
      frm_mem[0] <= {`RTPOAM_UDP_NIBBLE, l_bit_i, r_bit_i, m_bits_i,
                     `RTPOAM_UDP_RES, udp_len, tx_oam_seq};
      frm_mem[1] <= {tx_oam_type, tx_oam_code, `RTPOAM_SVC_NONE};
      frm_mem[2] <= {oam_bid_i, oam_dst_bid_i};
      frm_mem[3] <= oam_reply_i ? oam_src_time_i : us_time_reg;
      frm_mem[4] <= oam_reply_i ? oam_rx_time_i : `RTPOAM_TS_NONE;
      frm_mem[5] <= oam_reply_i ? us_time_reg : `RTPOAM_TS_NONE;
    end
  end

  // request acceptance, sequencing and output stream
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      state_reg <= ST_IDLE;
      rd_idx_reg <= 3'h0;
      last_idx_reg <= 3'h0;
      oam_seq_reg <= 16'h0000;
      ready_o <= 1'b1;
      tx_refused_o <= 1'b0;
      word_valid_o <= 1'b0;
      word_last_o <= 1'b0;
      word_o <= 32'h0000_0000;
      word_kind_o <= `RTPOAM_KIND_AAL1;
      psn_bid_o <= 16'h0000;
    end else if (ce_i) begin
      tx_refused_o <= 1'b0;
      word_valid_o <= 1'b0;
      word_last_o <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          rd_idx_reg <= 3'h0;
          if (tx_data_req_i) begin
            state_reg <= ST_SEND;
            ready_o <= 1'b0;
            last_idx_reg <= `RTPOAM_RTP_WORDS - 3'h1;
            word_kind_o <= tx_kind_i;
            psn_bid_o <= tx_bid_i;
          end else if (tx_vccv_req_i) begin
            state_reg <= ST_SEND;
            ready_o <= 1'b0;
            last_idx_reg <= delay_meas_i ?
              (`RTPOAM_VCCV_WORDS + `RTPOAM_TS_WORDS - 3'h1) :
              (`RTPOAM_VCCV_WORDS - 3'h1);
            word_kind_o <= `RTPOAM_KIND_OAM;
            psn_bid_o <= tx_bid_i; // same layers as data
            if (!oam_reply_i) begin
              oam_seq_reg <= oam_seq_reg + 16'h0001;
            end
          end else if (tx_udp_req_i) begin
            if (tx_bid_ok) begin
              state_reg <= ST_SEND;
              ready_o <= 1'b0;
              last_idx_reg <= delay_meas_i ?
                (`RTPOAM_UDP_WORDS + `RTPOAM_TS_WORDS - 3'h1) :
                (`RTPOAM_UDP_WORDS - 3'h1);
              word_kind_o <= `RTPOAM_KIND_OAM;
              psn_bid_o <= oam_bid_i; // only the bundle id differs
              if (!oam_reply_i) begin
                oam_seq_reg <= oam_seq_reg + 16'h0001; // queries number fresh
              end
            end else begin
              // unlisted id would reach the far end as tdm data
              tx_refused_o <= 1'b1;
            end
          end
        end
        ST_SEND: begin
          word_valid_o <= 1'b1;
          word_o <= frm_mem[rd_idx_reg];
          rd_idx_reg <= rd_idx_reg + 3'h1;
          if (rd_idx_reg == last_idx_reg) begin
            word_last_o <= 1'b1;
            state_reg <= ST_IDLE;
            ready_o <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          ready_o <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== core/rtpoam_tick_cnt.v ====
`default_nettype none
// counts rising edges of an asynchronous tick pin
module rtpoam_tick_cnt (
  input wire sys_clk_i,
  input wire srst_i,
  input wire ce_i,
  input wire pin_i,
  output reg [31:0] cnt_o
);
  reg sync1_reg;
  reg sync2_reg;
  reg sync3_reg;

  // two-flop synchroniser, third flop only for edge detect
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      cnt_o <= 32'h0000_0000;
    end else if (ce_i) begin
      sync1_reg <= pin_i;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      if (sync2_reg && !sync3_reg) begin
        cnt_o <= cnt_o + 32'h0000_0001; // wraps, as rtp time does
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/rtp_and_oam_header_format_tb_top.sv ====
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module rtp_and_oam_header_format_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] CT = 16'h0007; // arbitrary channel type
  localparam int CRS = 10; // short coarse stamp step keeps the run brief
  logic sys_clk_i, srst_i, tdm_frame_i, net_tick_i, ts_diff_mode_i, ts_coarse_i, delay_meas_i;
  logic new_session_i, tx_data_req_i, tx_vccv_req_i, tx_udp_req_i, oam_reply_i;
  logic oam_query_code_i, oam_mismatch_i, l_bit_i, r_bit_i, tbl_wr_i, tbl_en_i, rx_valid_i;
  logic [1:0] tx_kind_i, m_bits_i, word_kind_o;
  logic [2:0] tbl_idx_i;
  logic [3:0] rx_nibble_i;
  logic [6:0] tx_pt_i;
  logic [15:0] tx_seq_i, tx_bid_i, oam_rx_seq_i, oam_bid_i, oam_dst_bid_i, tbl_bid_i, rx_bid_i;
  logic [15:0] psn_bid_o;
  logic [31:0] oam_rx_time_i, oam_src_time_i, word_o, s1, sa;
  logic ready_o, tx_refused_o, word_valid_o, word_last_o, rx_vccv_o, rx_udp_oam_o, rx_data_o;
  logic [31:0] exq[$], got[$], prev[$];
  bit skq[$];
  int errors = 0, compares = 0, cyc = 0, ta = 0, tn = 0, q = 0, tk = 0, ka = 0, dd = 0;
  rtpoam_framer #(.CHAN_TYPE(CT), .COARSE_CYC(CRS[15:0])) u_dut (.sys_clk_i, .srst_i, .ce_i(1'b1),
    .tdm_frame_i, .net_tick_i, .ts_diff_mode_i, .ts_coarse_i, .delay_meas_i, .new_session_i,
    .tx_data_req_i, .tx_kind_i, .tx_seq_i, .tx_pt_i, .tx_bid_i, .tx_vccv_req_i, .tx_udp_req_i,
    .oam_reply_i, .oam_query_code_i, .oam_mismatch_i, .oam_rx_seq_i, .oam_rx_time_i,
    .oam_src_time_i, .oam_bid_i, .oam_dst_bid_i, .l_bit_i, .r_bit_i, .m_bits_i, .tbl_wr_i,
    .tbl_idx_i, .tbl_en_i, .tbl_bid_i, .rx_valid_i, .rx_nibble_i, .rx_bid_i, .ready_o,
    .tx_refused_o, .word_valid_o, .word_last_o, .word_o, .word_kind_o, .psn_bid_o, .rx_vccv_o,
    .rx_udp_oam_o, .rx_data_o);
  rtpoam_peer u_peer (.clk_i(sys_clk_i), .rx_valid_o(rx_valid_i), .rx_nibble_o(rx_nibble_i),
    .rx_bid_o(rx_bid_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // collect every framed word once it has settled
  always @(negedge sys_clk_i) if (word_valid_o === 1'b1) got.push_back(word_o);
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  function automatic void exw(input logic [31:0] v, input bit s);
    exq.push_back(v);
    skq.push_back(s);
  endfunction
  // type and code word of an oam message
  function automatic logic [31:0] cw();
    return {oam_reply_i ? 8'h08 : 8'h00, 7'h00,
      oam_reply_i ? oam_mismatch_i : oam_query_code_i, 16'h0000};
  endfunction
  // stamps: local time words cannot be predicted and are skipped
  function automatic void st();
    if (delay_meas_i) begin
      exw(oam_reply_i ? oam_src_time_i : 32'h0000_0000, !oam_reply_i);
      exw(oam_reply_i ? oam_rx_time_i : 32'h0000_0000, 1'b0);
      exw(32'h0000_0000, oam_reply_i);
    end
  endfunction
  task automatic pulse(input bit net, input int n);
    repeat (n) begin
      @(negedge sys_clk_i);
      if (net) net_tick_i = 1'b1; else tdm_frame_i = 1'b1;
      repeat (3) @(negedge sys_clk_i);
      {net_tick_i, tdm_frame_i} = 2'b00;
      repeat (3) @(negedge sys_clk_i);
      if (net) tn++; else ta++;
    end
  endtask
  task automatic go(input int w);
    int t;
    @(negedge sys_clk_i);
    tx_data_req_i = (w == 0);
    tx_vccv_req_i = (w == 1);
    tx_udp_req_i = (w == 2);
    tk = cyc; // taken at the next rising edge
    @(negedge sys_clk_i);
    {tx_data_req_i, tx_vccv_req_i, tx_udp_req_i} = 3'b000;
    for (t = 0; t < 60 && !(ready_o === 1'b1 && got.size() >= exq.size()); t++)
      @(negedge sys_clk_i);
    `CHK("count", exq.size(), got.size())
    foreach (exq[i]) if (!skq[i] && i < got.size()) `CHK("word", exq[i], got[i])
    prev = got;
    exq.delete();
    skq.delete();
    got.delete();
  endtask
  initial begin
    {srst_i, tdm_frame_i, net_tick_i, ts_diff_mode_i, ts_coarse_i, delay_meas_i} = '0;
    {new_session_i, tx_data_req_i, tx_vccv_req_i, tx_udp_req_i, oam_reply_i} = '0;
    {oam_query_code_i, oam_mismatch_i, l_bit_i, r_bit_i, m_bits_i, tbl_wr_i, tbl_en_i} = '0;
    {tx_kind_i, tbl_idx_i, tx_pt_i, tx_seq_i, tx_bid_i, tbl_bid_i} = '0;
    void'($urandom(32'h2a1ff7cc));
    {oam_rx_seq_i, oam_bid_i, oam_dst_bid_i} = 48'({$urandom, $urandom});
    {oam_rx_time_i, oam_src_time_i} = {$urandom, $urandom};
    srst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    srst_i = 1'b0;
    // every payload kind, absolute then network clock stamps
    for (int m = 0; m < 2; m++) for (int k = 0; k < 4; k++) begin
      ts_diff_mode_i = m[0];
      tx_kind_i = k[1:0];
      tx_seq_i = 16'($urandom);
      tx_bid_i = 16'($urandom);
      tx_pt_i = 7'd96 + 7'($urandom % 32);
      pulse(m[0], k + 1);
      exw({2'b10, 7'h00, tx_pt_i, tx_seq_i}, 1'b0);
      exw(m ? tn : ta, 1'b0);
      exw(32'h0000_0000, 1'b1);
      go(0);
      `CHK("kind", tx_kind_i, word_kind_o)
    end
    s1 = prev[2];
    @(negedge sys_clk_i) new_session_i = 1'b1;
    @(negedge sys_clk_i) new_session_i = 1'b0;
    exw(32'h0000_0000, 1'b1);
    exw(32'h0000_0000, 1'b1);
    exw(32'h0000_0000, 1'b1);
    go(0);
    `CHK("sync_source_identifier new", 1'b1, prev[2] !== s1)
    $display("test rtp done");
    // inband oam, then udp oam refused before the table holds its id
    for (int i = 0; i < 8; i++) begin
      {delay_meas_i, oam_reply_i, oam_query_code_i} = i[2:0];
      oam_mismatch_i = i[0];
      if (!oam_reply_i) q++; // inband queries draw from the same oam numbering
      exw({4'h1, 4'h0, 8'h00, CT}, 1'b0);
      exw(cw(), 1'b0);
      st();
      go(1);
      `CHK("vccv bid", tx_bid_i, psn_bid_o)
    end
    go(2);
    `CHK("refused", 1'b1, tx_refused_o)
    @(negedge sys_clk_i) {tbl_wr_i, tbl_idx_i, tbl_en_i, tbl_bid_i} = {4'hb, 1'b1, oam_bid_i};
    @(negedge sys_clk_i) tbl_wr_i = 1'b0;
    ts_coarse_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      {delay_meas_i, oam_reply_i, oam_query_code_i} = i[2:0];
      oam_mismatch_i = i[0];
      {l_bit_i, r_bit_i, m_bits_i} = 4'($urandom);
      exw({4'h0, l_bit_i, r_bit_i, m_bits_i, 2'b00, delay_meas_i ? 6'h18 : 6'h0c,
        oam_reply_i ? oam_rx_seq_i : 16'(q)}, 1'b0);
      if (!oam_reply_i) q++;
      exw(cw(), 1'b0);
      exw({oam_bid_i, oam_dst_bid_i}, 1'b0);
      st();
      // a gap between the two stamped queries spans several coarse steps
      if (i == 5) repeat (40) @(negedge sys_clk_i);
      go(2);
      `CHK("udp bid", oam_bid_i, psn_bid_o)
      if (i == 4) begin
        sa = prev[3];
        ka = tk;
      end
      if (i == 5) begin
        dd = (prev[3] - sa) * CRS - (tk - ka);
        `CHK("stamp step", 1'b1, dd >= -CRS && dd <= CRS)
      end
    end
    $display("test oam done");
    // receive side: inband marker, plain data, table id
    for (int j = 0; j < 3; j++) begin
      u_peer.send(j == 0 ? 4'h1 : 4'h0, j == 2 ? oam_bid_i : ~oam_bid_i);
      `CHK("rx class", j == 0 ? 3'b010 : (j == 1 ? 3'b001 : 3'b100),
        {rx_udp_oam_o, rx_vccv_o, rx_data_o})
    end
    $display("test rx done");
    conclude();
  end
endmodule
`default_nettype wire

// ==== tb/rtpoam_checker.sv ====
`default_nettype none
module rtpoam_checker #(
  parameter [15:0] CHAN_TYPE = 16'h0001
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic tx_data_req_i,
  input wire logic tx_vccv_req_i,
  input wire logic [15:0] tx_seq_i,
  input wire logic [6:0] tx_pt_i,
  input wire logic rx_valid_i,
  input wire logic [3:0] rx_nibble_i,
  input wire logic ready_o,
  input wire logic tx_refused_o,
  input wire logic word_valid_o,
  input wire logic word_last_o,
  input wire logic [31:0] word_o,
  input wire logic rx_vccv_o,
  input wire logic rx_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // clock enable stays high on the bench, so a take is ready plus request
  wire take_rtp = ready_o && tx_data_req_i;
  wire take_vccv = ready_o && !tx_data_req_i && tx_vccv_req_i;
  hdr_version_a: assert property (
      take_rtp |-> ##2 word_valid_o && word_o[31:30] == 2'h2)
    else $error("rtp version field wrong");
  hdr_zero_a: assert property (take_rtp |-> ##2 word_o[29:23] == 7'h00)
    else $error("rtp p x cc m not zero");
  hdr_pt_a: assert property (take_rtp |-> ##2 word_o[22:16] == $past(tx_pt_i, 2))
    else $error("rtp payload type not copied");
  hdr_seq_a: assert property (take_rtp |-> ##2 word_o[15:0] == $past(tx_seq_i, 2))
    else $error("rtp sequence not copied");
  rtp_len_a: assert property (
      take_rtp |-> ##1 !ready_o ##1 (word_valid_o && !word_last_o)[*2]
      ##1 (word_valid_o && word_last_o && ready_o))
    else $error("rtp header not three words");
  vccv_head_a: assert property (
      take_vccv |-> ##2 word_valid_o && word_o[31:16] == 16'h1000)
    else $error("inband oam head wrong");
  vccv_chan_a: assert property (take_vccv |-> ##2 word_o[15:0] == CHAN_TYPE)
    else $error("inband oam channel type wrong");
  rx_vccv_a: assert property (
      rx_vccv_o |-> $past(rx_valid_i) && $past(rx_nibble_i) == 4'h1)
    else $error("inband oam flagged without marker nibble");
  rx_divert_a: assert property (rx_valid_i && rx_nibble_i == 4'h1 |=> !rx_data_o)
    else $error("inband oam reached data path");
  udp_refuse_a: assert property (tx_refused_o |-> ready_o && !word_valid_o)
    else $error("refused oam still framed");
endmodule
bind rtpoam_framer rtpoam_checker #(.CHAN_TYPE(CHAN_TYPE)) u_chk (.sys_clk_i(sys_clk_i),
  .srst_i(srst_i), .tx_data_req_i(tx_data_req_i), .tx_vccv_req_i(tx_vccv_req_i),
  .tx_seq_i(tx_seq_i), .tx_pt_i(tx_pt_i), .rx_valid_i(rx_valid_i), .rx_nibble_i(rx_nibble_i),
  .ready_o(ready_o), .tx_refused_o(tx_refused_o), .word_valid_o(word_valid_o),
  .word_last_o(word_last_o), .word_o(word_o), .rx_vccv_o(rx_vccv_o), .rx_data_o(rx_data_o));
`default_nettype wire

// ==== tb/rtpoam_peer.sv ====
`default_nettype none
// remote gateway: hands packet heads to the receive side
module rtpoam_peer (
  input wire logic clk_i,
  output logic rx_valid_o,
  output logic [3:0] rx_nibble_o,
  output logic [15:0] rx_bid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rx_valid_o = 1'b0;
    rx_nibble_o = 4'h0;
    rx_bid_o = 16'h0000;
  end
  // released lines show the inverse, so a stale head never looks valid
  task automatic send(input logic [3:0] nib, input logic [15:0] bid);
    @(negedge clk_i);
    rx_valid_o = 1'b1;
    rx_nibble_o = nib;
    rx_bid_o = bid;
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_nibble_o = ~nib;
    rx_bid_o = ~bid;
  endtask
endmodule
`default_nettype wire
